/* File: bench/bit_rate_generator_monitor.sv */
// checker for the bit rate generator, bound to its top ports
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module bit_rate_generator_monitor (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       osc_in,
	input wire logic       ext_timing_in,
	input wire logic       ext_timing_select_n,
	input wire logic [3:0] rate_code,
	input wire logic       mux_aux_in,
	input wire logic       master_clk_out,
	input wire logic       rate_out,
	input wire logic [2:0] scan_count,
	input wire logic       avs_read,
	input wire logic       avs_write,
	input wire logic       avs_waitrequest
);
	logic [3:0] still_r;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// aux held still with an aux code; syncers need a few cycles
	always_ff @(posedge clk)
		if (rst || rate_code[3:1] != 3'h0 || $changed(mux_aux_in))
			still_r <= 4'h0;
		else if (still_r != 4'hF)
			still_r <= still_r + 4'h1;
	AST_RATE_EDGE:
		assert property (ext_timing_select_n && $past(ext_timing_select_n, 4)
			&& !$stable(rate_out) |-> $rose(master_clk_out))
		else $error("rate output moved off a master edge");
	AST_SCAN_STEP:
		assert property ($rose(master_clk_out) && ext_timing_select_n
			&& $past(ext_timing_select_n, 4) && !$past(rst, 3)
			|-> scan_count == $past(scan_count) + 3'h1)
		else $error("scan count did not step by one");
	AST_OSC_OUT:
		assert property ($changed(osc_in) && $past(ext_timing_select_n, 3)
			##0 ext_timing_select_n[*4] |-> master_clk_out == $past(osc_in, 3))
		else $error("clock out does not follow the oscillator");
	AST_EXT_ONLY:
		assert property ((!ext_timing_select_n && !ext_timing_in)[*5]
			|-> !master_clk_out)
		else $error("oscillator leaks in external mode");
	AST_INIT_CLEAR:
		assert property ($fell(ext_timing_select_n) ##1
			(!ext_timing_select_n && !ext_timing_in)[*5]
			|-> scan_count == 3'h0 && !rate_out)
		else $error("select fall did not clear the chains");
	AST_AUX_ROUTE:
		assert property ($rose(master_clk_out) && still_r > 4'h5
			&& ext_timing_select_n |-> rate_out == mux_aux_in)
		else $error("aux input not routed to rate output");
	AST_ONE_WAIT:
		assert property ((avs_read || avs_write) && avs_waitrequest
			|=> !avs_waitrequest)
		else $error("bus answer not after one wait state");
	AST_WAIT_PULSE:
		assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than a cycle");
endmodule
bind bit_rate_generator bit_rate_generator_monitor u_bit_rate_generator_monitor (
	.clk(clk), .rst(rst), .osc_in(osc_in), .ext_timing_in(ext_timing_in),
	.ext_timing_select_n(ext_timing_select_n), .rate_code(rate_code),
	.mux_aux_in(mux_aux_in), .master_clk_out(master_clk_out),
	.rate_out(rate_out), .scan_count(scan_count), .avs_read(avs_read),
	.avs_write(avs_write), .avs_waitrequest(avs_waitrequest)
);
`default_nettype wire

/* File: bench/tb_bit_rate_generator.sv */
// self-checking bench for the bit rate generator
// assumes design, partner model and monitor are compiled before it
`timescale 1ns/10ps
`default_nettype none
module tb_bit_rate_generator;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        osc_in = 1'b0;
	logic        ext_timing_in = 1'b0;
	logic        ext_timing_select_n = 1'b1;
	logic [3:0]  rate_code = 4'h0;
	logic        mux_aux_in = 1'b0;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [3:0]  code_r = 4'h0;
	logic        aux_r = 1'b0;
	logic        multi = 1'b0;
	logic [1:0]  osc_cnt = 2'h0;
	wire         master_clk_out, rate_out, avs_waitrequest, aux_q;
	wire  [2:0]  scan_count;
	wire  [31:0] avs_readdata;
	wire  [3:0]  chan_code;
	wire  [7:0]  latch_q;
	int          err_count = 0;
	int          n_checks = 0;
	bit_rate_generator u_bit_rate_generator (.clk(clk), .rst(rst),
		.osc_in(osc_in), .ext_timing_in(ext_timing_in),
		.ext_timing_select_n(ext_timing_select_n), .rate_code(rate_code),
		.mux_aux_in(mux_aux_in), .master_clk_out(master_clk_out),
		.rate_out(rate_out), .scan_count(scan_count),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hF), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest));
	uart_clock_partner u_uart_clock_partner (.clk(clk),
		.master_clk_out(master_clk_out), .rate_out(rate_out),
		.scan_count(scan_count), .chan_code(chan_code), .aux_q(aux_q),
		.latch_q(latch_q));
	initial
		forever #5 clk = ~clk;
	// oscillator at half period four clocks keeps syncer margin
	always @(posedge clk)
	begin
		osc_cnt <= osc_cnt + 2'h1;
		if (osc_cnt == 2'h3)
			osc_in <= !osc_in;
		rate_code <= multi ? chan_code : code_r;
		mux_aux_in <= multi ? aux_q : aux_r;
	end
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic stall();
		err_count++;
		$display("wrong value at %0t: wait ran out", $time);
		wrap_up();
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [3:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int t;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		for (t = 0; t < 50; t++)
		begin
			@(posedge clk);
			if (avs_waitrequest === 1'b0)
				break;
		end
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (t == 50)
			stall();
	endtask
	// master rises while rate holds lvl, or until lim rises if lim set
	task automatic run(input logic lvl, input int lim, output int n);
		int t;
		logic pm;
		n = 0;
		pm = master_clk_out;
		for (t = 0; t < 30000 && (lim == 0 ? rate_out === lvl : n < lim); t++)
		begin
			@(posedge clk);
			if ({pm, master_clk_out} === 2'b01)
				n++;
			pm = master_clk_out;
		end
		if (t == 30000)
			stall();
	endtask
	task automatic t_regs();
		logic [31:0] q;
		bus(0, 4'h0, '0, q);
		chk(q, 32'h0000_0000);
		bus(1, 4'h0, 32'hFFFF_FFA0, q);
		bus(0, 4'h0, '0, q);
		chk(q, 32'h0000_00A0);
		bus(1, 4'hC, 32'hFFFF_FFFF, q);
		bus(0, 4'hC, '0, q);
		chk(q, 32'h0000_0000);
		bus(0, 4'h4, '0, q);
		chk(32'(q[4]), 0);
		bus(1, 4'h0, '0, q);
	endtask
	task automatic t_aux();
		logic [31:0] q, p;
		int k, d;
		for (k = 0; k < 4; k++)
		begin
			@(posedge clk);
			code_r <= 4'(k[0]);
			aux_r <= !k[1];
			run(0, 3, d);
			chk(32'(rate_out), 32'(!k[1]));
		end
		run(0, 1, d);
		bus(0, 4'h8, '0, q);
		@(posedge clk);
		code_r <= 4'h8;
		run(0, 16, d);
		bus(0, 4'h8, '0, p);
		chk(32'(p[7:0] - q[7:0]), 2);
	endtask
	task automatic t_scan();
		int d;
		@(posedge clk);
		multi <= 1'b1;
		run(0, 20, d);
		chk(32'(latch_q), 32'h0000_00E1);
		multi <= 1'b0;
	endtask
	task automatic t_ext();
		logic [31:0] q;
		int k, d;
		@(posedge clk);
		ext_timing_select_n <= 1'b0;
		repeat (10) @(posedge clk);
		chk(32'(scan_count), 0);
		bus(0, 4'h4, '0, q);
		chk(32'(q[5:4]), 3);
		// first high phase only resets, later ones count
		for (k = 0; k < 6; k++)
		begin
			@(posedge clk);
			ext_timing_in <= 1'b1;
			repeat (6) @(posedge clk);
			chk(32'(master_clk_out), 1);
			ext_timing_in <= 1'b0;
			repeat (6) @(posedge clk);
			chk(32'(scan_count), k);
		end
		bus(0, 4'h4, '0, q);
		chk(32'(q[5:4]), 1);
		@(posedge clk);
		ext_timing_select_n <= 1'b1;
		run(0, 4, d);
	endtask
	task automatic t_rates();
		int hp [16];
		int c, h, s, k;
		logic [31:0] q;
		hp = '{0, 0, 1536, 1024, 576, 384, 128, 32, 8, 16, 48, 64, 32, 256,
			512, 704};
		for (c = 2; c < 16; c++)
		begin
			// last code comes from the register while pins ask for 50 baud
			if (c == 15)
				bus(1, 4'h0, 32'h0000_00F1, q);
			@(posedge clk);
			code_r <= (c == 15) ? 4'h2 : 4'(c);
			run(0, 2, h);
			// partial phase, then one whole phase: keeps the run short
			run(rate_out, 0, h);
			run(rate_out, 0, h);
			if (c == 10 && rate_out)
				run(1, 0, h);
			chk(h, hp[c]);
			s = h;
			for (k = 0; c == 10 && k < 5; k++)
			begin
				run(rate_out, 0, h);
				s += h;
			end
			if (c == 10)
				chk(s, 256);
		end
		bus(1, 4'h0, '0, q);
	endtask
	initial
	begin
		repeat (5) @(posedge clk);
		chk(32'({master_clk_out, rate_out, scan_count, avs_waitrequest}), 1);
		rst <= 1'b0;
		t_regs();
		t_aux();
		t_scan();
		t_ext();
		t_rates();
		wrap_up();
	end
endmodule
`default_nettype wire

/* File: bench/uart_clock_partner.sv */
// far side: per-channel rate store and addressable output latch
// assumes scan count and rate output from the generator, one clock
`timescale 1ns/10ps
`default_nettype none
module uart_clock_partner (
	input wire logic        clk,
	input wire logic        master_clk_out,
	input wire logic        rate_out,
	input wire logic [2:0]  scan_count,
	output var logic [3:0]  chan_code,
	output var logic        aux_q,
	output var logic [7:0]  latch_q
);
	// code per channel by scan count; top scan bit wired to aux
	always @(posedge clk)
	begin
		chan_code <= {3'h0, scan_count[0]};
		aux_q <= scan_count[2];
	end
	// latch loads only while clock out is low, so it holds on changes
	always @(posedge clk)
		if (!master_clk_out)
			latch_q[scan_count] <= rate_out;
endmodule
`default_nettype wire

/* File: hdl/bit_rate_generator.v */
// programmable bit rate generator with scan counter for eight channels
// assumes osc, external timing and rate pins are asynchronous to clk,
// and a master timing far slower than clk (a few MHz against 100 MHz)
`timescale 1ns/10ps
`include "bit_rate_generator_defines.vh"
`default_nettype none

module bit_rate_generator (
	input  wire        clk,
	input  wire        rst,
	input  wire        osc_in,
	input  wire        ext_timing_in,
	input  wire        ext_timing_select_n,
	input  wire [3:0]  rate_code,
	input  wire        mux_aux_in,
	output reg         master_clk_out,
	output reg         rate_out,
	output reg  [2:0]  scan_count,
	input  wire [3:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	input  wire [3:0]  avs_byteenable,
	output reg  [31:0] avs_readdata,
	output reg         avs_waitrequest
);

	// true when chain bit k goes 0 to 1 on this carry
	function bit_rises;
		input [7:0] c;
		input [2:0] k;
		reg   [7:0] lowm;
		begin
			lowm      = (8'h01 << k) - 8'h01;
			bit_rises = ((c & lowm) == lowm) & ~c[k];
		end
	endfunction

	// two-flop synchronisers for every pin input
	reg  [7:0] sync1_r;
	reg  [7:0] sync2_r;
	wire       osc_s;
	wire       ext_s;
	wire       sel_n_s;
	wire       aux_s;
	wire [3:0] code_s;

	always @(posedge clk)
	begin
		if (rst)
		begin
			// select idles high: a low reset value would fake a fall
			sync1_r <= 8'h04;
			sync2_r <= 8'h04;
		end
		else
		begin
			sync1_r <= {mux_aux_in, rate_code, ext_timing_select_n,
				ext_timing_in, osc_in};
			sync2_r <= sync1_r;
		end
	end

	assign osc_s   = sync2_r[0];
	assign ext_s   = sync2_r[1];
	assign sel_n_s = sync2_r[2];
	assign code_s  = sync2_r[6:3];
	assign aux_s   = sync2_r[7];

	// master timing select and initialization state
	reg  init_r;
	reg  sel_prev_r;
	reg  ext_prev_r;
	reg  master_prev_r;
	wire ext_mode;
	wire master_lvl;
	wire tick;
	wire clr;

	assign ext_mode   = ~sel_n_s;
	assign master_lvl = ext_mode ? ext_s : osc_s;
	assign tick       = master_lvl & ~master_prev_r & ~init_r;
	assign clr        = rst | init_r;

	// reset holds from select fall through the first external high phase
	always @(posedge clk)
	begin
		if (rst)
		begin
			init_r        <= 1'b1;
			sel_prev_r    <= 1'b1;
			ext_prev_r    <= 1'b0;
			master_prev_r <= 1'b0;
		end
		else
		begin
			sel_prev_r    <= sel_n_s;
			ext_prev_r    <= ext_s;
			master_prev_r <= master_lvl;
			if (sel_prev_r & ~sel_n_s)
				init_r <= 1'b1;
			else if (~ext_mode)
				init_r <= 1'b0;
			else if (ext_prev_r & ~ext_s)
				init_r <= 1'b0;
		end
	end

	// clock output mirrors master timing, one clk late like the counters
	always @(posedge clk)
	begin
		if (rst)
			master_clk_out <= 1'b0;
		else
			master_clk_out <= master_lvl;
	end

	// scan counter and 8-bit chain, never gated by the rate code
	reg  [7:0] chain_r;
	wire       carry;

	assign carry = tick & (scan_count == `SCAN_LAST);

	always @(posedge clk)
	begin
		if (clr)
		begin
			scan_count <= 3'h0;
			chain_r    <= 8'h00;
		end
		else
		begin
			if (tick)
				scan_count <= scan_count + 3'h1;
			if (carry)
				chain_r <= chain_r + 8'h01;
		end
	end

	// chain bit 0 is 16x 9600 baud: 2.4576 MHz / 8 / 2
	wire rise_9600;
	wire rise_2400;
	wire rise_1200;
	wire rise_200;
	wire clk_1800;
	wire clk_110;
	wire clk_134;
	wire clk_200;
	wire clk_50;

	assign rise_9600 = carry & bit_rises(chain_r, 3'd0);
	assign rise_2400 = carry & bit_rises(chain_r, 3'd2);
	assign rise_1200 = carry & bit_rises(chain_r, 3'd3);

	frac_divider u_div_1800 (
		.clk      (clk),
		.rst      (clr),
		.src_rise (rise_9600),
		.clk_o    (clk_1800)
	);

	even_divider #(.DIV(`DIV_110)) u_div_110 (
		.clk      (clk),
		.rst      (clr),
		.src_rise (rise_2400),
		.clk_o    (clk_110),
		.rise_o   ()
	);

	even_divider #(.DIV(`DIV_134)) u_div_134 (
		.clk      (clk),
		.rst      (clr),
		.src_rise (rise_2400),
		.clk_o    (clk_134),
		.rise_o   ()
	);

	even_divider #(.DIV(`DIV_200)) u_div_200 (
		.clk      (clk),
		.rst      (clr),
		.src_rise (rise_1200),
		.clk_o    (clk_200),
		.rise_o   (rise_200)
	);

	// the 200 strobe lags one clk; harmless against a slow master edge
	even_divider #(.DIV(`DIV_50)) u_div_50 (
		.clk      (clk),
		.rst      (clr),
		.src_rise (rise_200),
		.clk_o    (clk_50),
		.rise_o   ()
	);

	// control register: software may override the rate code pins
	reg  [7:0] ctrl_r;
	wire [3:0] code_sel;

	assign code_sel = ctrl_r[`CTRL_USE_SW_BIT]
		? ctrl_r[`CTRL_CODE_MSB:`CTRL_CODE_LSB] : code_s;

	// rate multiplexer
	reg mux_out;

	always @*
	begin
		case (code_sel)
		4'h0, 4'h1: mux_out = aux_s;
		4'h2: mux_out = clk_50;
		4'h3: mux_out = chain_r[7];
		4'h4: mux_out = clk_134;
		4'h5: mux_out = clk_200;
		4'h6: mux_out = chain_r[4];
		4'h7: mux_out = chain_r[2];
		4'h8: mux_out = chain_r[0];
		4'h9: mux_out = chain_r[1];
		4'hA: mux_out = clk_1800;
		4'hB: mux_out = chain_r[3];
		4'hC: mux_out = chain_r[2];
		4'hD: mux_out = chain_r[5];
		4'hE: mux_out = chain_r[6];
		4'hF: mux_out = clk_110;
		default: mux_out = 1'b0;
		endcase
	end

	// output flip-flop samples the old mux value on the scan edge
	always @(posedge clk)
	begin
		if (clr)
			rate_out <= 1'b0;
		else if (tick)
			rate_out <= mux_out;
	end

	// avalon slave: one wait cycle, then the access completes
	wire req;
	wire done;
	reg  [31:0] rd_nxt;

	assign req  = avs_read | avs_write;
	assign done = req & ~avs_waitrequest;

	always @*
	begin
		rd_nxt = 32'h0000_0000;
		case (avs_address)
		`OFS_CTRL:
			rd_nxt[7:0] = ctrl_r;
		`OFS_STATUS:
		begin
			rd_nxt[`STAT_SCAN_MSB:`STAT_SCAN_LSB] = scan_count;
			rd_nxt[`STAT_RATE_BIT]   = rate_out;
			rd_nxt[`STAT_EXT_BIT]    = ext_mode;
			rd_nxt[`STAT_INIT_BIT]   = init_r;
			rd_nxt[`STAT_MASTER_BIT] = master_lvl;
		end
		`OFS_CHAIN:
			rd_nxt[7:0] = chain_r;
		default:
			rd_nxt = 32'h0000_0000; // unmapped reads zero
		endcase
	end

	always @(posedge clk)
	begin
		if (rst)
		begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
			ctrl_r          <= `CTRL_RST;
		end
		else
		begin
			avs_waitrequest <= ~(req & avs_waitrequest);
			if (req & avs_waitrequest)
				avs_readdata <= rd_nxt;
			if (done & avs_write & avs_byteenable[0]
				& (avs_address == `OFS_CTRL))
				ctrl_r <= avs_writedata[7:0];
		end
	end

endmodule
`default_nettype wire

/* File: hdl/bit_rate_generator_defines.vh */
// register map, field positions, reset values and division counts
// shared by the bit rate generator and its fractional divider module
// assumes a 32-bit avalon slave with byte addresses on 4 bits
`ifndef BIT_RATE_GENERATOR_DEFINES_VH
`define BIT_RATE_GENERATOR_DEFINES_VH

// register byte offsets
`define OFS_CTRL         4'h0
`define OFS_STATUS       4'h4
`define OFS_CHAIN        4'h8

// control register fields and reset value
`define CTRL_USE_SW_BIT  0
`define CTRL_CODE_LSB    4
`define CTRL_CODE_MSB    7
`define CTRL_RST         8'h00

// status register fields
`define STAT_SCAN_LSB    0
`define STAT_SCAN_MSB    2
`define STAT_RATE_BIT    3
`define STAT_EXT_BIT     4
`define STAT_INIT_BIT    5
`define STAT_MASTER_BIT  6

// scan counter and divider counts
`define SCAN_LAST        3'h7
`define DIV_110          22
`define DIV_134          18
`define DIV_200          6
`define DIV_50           4
`define FRAC_SHORT       5
`define FRAC_LONG        6
`define FRAC_HIGH        3
`define FRAC_PHASES      3

`endif

/* File: hdl/even_divider.v */
// even integer divider of a rate clock given as rising-edge strobes
// assumes src_rise is a one-cycle pulse on the system clock
`timescale 1ns/10ps
`default_nettype none

module even_divider #(
	parameter DIV = 4
) (
	input  wire clk,
	input  wire rst,
	input  wire src_rise,
	output reg  clk_o,
	output reg  rise_o
);

	// the count is four bits wide, so DIV may reach 32
	localparam [31:0] HALF_WIDE = DIV / 2 - 1;
	localparam [3:0]  HALF_LAST = HALF_WIDE[3:0];

	reg [3:0] cnt_r;

	// toggle every DIV/2 source edges, so the duty stays at one half
	always @(posedge clk)
	begin
		if (rst)
		begin
			cnt_r  <= 4'h0;
			clk_o  <= 1'b0;
			rise_o <= 1'b0;
		end
		else
		begin
			rise_o <= 1'b0;
			if (src_rise)
			begin
				if (cnt_r == HALF_LAST)
				begin
					cnt_r  <= 4'h0;
					clk_o  <= ~clk_o;
					rise_o <= ~clk_o; // rise strobe feeds a later stage
				end
				else
					cnt_r <= cnt_r + 4'h1;
			end
		end
	end

endmodule
`default_nettype wire

/* File: hdl/frac_divider.v */
// divide-by-16/3 of a rate clock given as rising-edge strobes
// assumes src_rise is a one-cycle pulse on the system clock
`timescale 1ns/10ps
`include "bit_rate_generator_defines.vh"
`default_nettype none

module frac_divider (
	input  wire clk,
	input  wire rst,
	input  wire src_rise,
	output reg  clk_o
);

	reg [2:0] cnt_r;
	reg [1:0] phase_r;
	reg [2:0] last;
	reg [2:0] cnt_nxt;
	reg [1:0] phase_nxt;

	// periods 5,5,6: sixteen source cycles per three outputs, error back to 0
	always @*
	begin
		last      = (phase_r == 2'd2) ? 3'd`FRAC_LONG - 3'd1
			: 3'd`FRAC_SHORT - 3'd1;
		cnt_nxt   = cnt_r;
		phase_nxt = phase_r;
		if (src_rise)
		begin
			if (cnt_r == last)
			begin
				cnt_nxt   = 3'd0;
				phase_nxt = (phase_r == 2'd`FRAC_PHASES - 2'd1) ? 2'd0
					: phase_r + 2'd1;
			end
			else
				cnt_nxt = cnt_r + 3'd1;
		end
	end

	// high for three source cycles of each period; duty not symmetric
	always @(posedge clk)
	begin
		if (rst)
		begin
			cnt_r   <= 3'd0;
			phase_r <= 2'd0;
			clk_o   <= 1'b0;
		end
		else
		begin
			cnt_r   <= cnt_nxt;
			phase_r <= phase_nxt;
			clk_o   <= (cnt_nxt < 3'd`FRAC_HIGH);
		end
	end

endmodule
`default_nettype wire
